/* File: rtl/ddc_ctrl.sv */
`timescale 1ns/10ps
`include "ddc_params.svh"
module ddc_ctrl #(
    parameter int CODE_W = 16
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Decoded command from the serial front end
    input  wire ddc_pkg::ddc_word_t   cmd_word,
    input  wire logic                 cmd_valid,
    input  wire logic                 write_busy,
    input  wire logic                 hs_mode,
    // Pins
    input  wire logic                 load_strobe_n,
    input  wire logic                 async_zero_n,
    // Results
    output logic [CODE_W-1:0]         dac_code_a,
    output logic [CODE_W-1:0]         dac_code_b,
    output ddc_pkg::ddc_pwr_pair_t    pwr_mode,
    output logic                      ref_enable,
    output logic [1:0]                load_bypass,
    output logic                      clear_mode,
    output logic                      write_abort,
    output logic                      hs_exit,
    output logic                      shift_clear
);
    import ddc_pkg::*;

    // -----------------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------------
    logic ls_level;
    logic ls_fall;
    logic az_level;
    logic az_fall;

    ddc_pin_sync u_ls_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin_in  (load_strobe_n),
        .level   (ls_level),
        .fall    (ls_fall)
    );

    ddc_pin_sync u_az_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin_in  (async_zero_n),
        .level   (az_level),
        .fall    (az_fall)
    );

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    logic [CODE_W-1:0] in_a_q;
    logic [CODE_W-1:0] in_a_d;
    logic [CODE_W-1:0] in_b_q;
    logic [CODE_W-1:0] in_b_d;
    logic [CODE_W-1:0] dac_a_q;
    logic [CODE_W-1:0] dac_a_d;
    logic [CODE_W-1:0] dac_b_q;
    logic [CODE_W-1:0] dac_b_d;
    logic [1:0]        dirty_q;
    logic [1:0]        dirty_d;
    logic [1:0]        mask_q;
    logic [1:0]        mask_d;
    ddc_pwr_pair_t     pwr_q;
    ddc_pwr_pair_t     pwr_d;
    logic              ref_q;
    logic              ref_d;
    logic              clr_q;
    logic              clr_d;
    logic [2:0]        por_cnt_q;
    logic              abort_q;
    logic              hsx_q;
    logic              shclr_q;

    // Power-on reset window: pin events stay masked until the synchronisers have
    // flushed whatever the pins did while reset was held.
    wire por_done = (por_cnt_q == `DDC_POR_CYC);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            por_cnt_q <= 3'h0;
        end else if (!por_done) begin
            por_cnt_q <= por_cnt_q + 3'h1;
        end
    end

    // -----------------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------------
    wire        pins_live  = por_done;
    wire [CODE_W-1:0] code_zero = CODE_W'(`DDC_CODE_RST);
    wire        clr_evt    = pins_live & az_fall;
    wire        accept     = cmd_valid & ~clr_evt;
    wire [2:0]  cmd        = cmd_word.cmd;
    wire [2:0]  addr       = cmd_word.addr;
    wire [CODE_W-1:0] code = cmd_word.data[15 -: CODE_W];
    wire        hit_a      = (addr == `DDC_ADDR_A) || (addr == `DDC_ADDR_BOTH);
    wire        hit_b      = (addr == `DDC_ADDR_B) || (addr == `DDC_ADDR_BOTH);
    wire        is_wr      = (cmd == `DDC_CMD_WR_IN) || (cmd == `DDC_CMD_WR_ALL)
                             || (cmd == `DDC_CMD_WR_UPD);
    wire        wr_a       = accept & is_wr & hit_a;
    wire        wr_b       = accept & is_wr & hit_b;
    wire        sw_all     = accept & (cmd == `DDC_CMD_WR_ALL);
    wire        upd_a      = accept & hit_a &
                             ((cmd == `DDC_CMD_UPD) || (cmd == `DDC_CMD_WR_UPD));
    wire        upd_b      = accept & hit_b &
                             ((cmd == `DDC_CMD_UPD) || (cmd == `DDC_CMD_WR_UPD));
    wire        do_pwr     = accept & (cmd == `DDC_CMD_PWR);
    wire        do_rst     = accept & (cmd == `DDC_CMD_RST);
    wire        rst_full   = do_rst & cmd_word.data[0];
    wire        do_mask    = accept & (cmd == `DDC_CMD_MASK);
    wire        do_ref     = accept & (cmd == `DDC_CMD_REF);
    wire [1:0]  pwr_field  = cmd_word.data[`DDC_PWR_HI:`DDC_PWR_LO];
    // Strobe acts only when clear is high and power-on reset is over.
    wire        strobe_ok  = pins_live & az_level & ~clr_evt;
    wire        strobe_low = strobe_ok & ~ls_level;
    wire        strobe_go  = strobe_low | (strobe_ok & ls_fall);

    // -----------------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------------
    always_comb begin
        in_a_d  = in_a_q;
        in_b_d  = in_b_q;
        dac_a_d = dac_a_q;
        dac_b_d = dac_b_q;
        dirty_d = dirty_q;
        mask_d  = mask_q;
        pwr_d   = pwr_q;
        ref_d   = ref_q;
        clr_d   = clr_q;
        if (wr_a) begin
            in_a_d     = code;
            dirty_d[0] = 1'b1;
        end
        if (wr_b) begin
            in_b_d     = code;
            dirty_d[1] = 1'b1;
        end
        // Channel A transfer: strobe, bypass mask, or software update.
        if ((dirty_d[0] && (strobe_go || mask_q[0])) || upd_a || sw_all) begin
            dac_a_d    = in_a_d;
            dirty_d[0] = 1'b0;
        end
        if ((dirty_d[1] && (strobe_go || mask_q[1])) || upd_b || sw_all) begin
            dac_b_d    = in_b_d;
            dirty_d[1] = 1'b0;
        end
        if (do_mask) begin
            mask_d = cmd_word.data[1:0];
        end
        if (do_pwr) begin
            if (cmd_word.data[`DDC_SEL_A]) begin
                pwr_d.mode_a = ddc_pwr_t'(pwr_field);
            end
            if (cmd_word.data[`DDC_SEL_B]) begin
                pwr_d.mode_b = ddc_pwr_t'(pwr_field);
            end
        end
        if (do_ref) begin
            ref_d = cmd_word.data[0];
        end
        if (do_rst) begin
            in_a_d  = code_zero;
            in_b_d  = code_zero;
            dac_a_d = code_zero;
            dac_b_d = code_zero;
            dirty_d = 2'h0;
        end
        if (rst_full) begin
            mask_d = `DDC_MASK_RST;
            pwr_d  = '{mode_b: DDC_PWR_NORMAL, mode_a: DDC_PWR_NORMAL};
            ref_d  = `DDC_REF_RST;
        end
        if (accept && is_wr) begin
            clr_d = 1'b0;
        end
        if (clr_evt) begin
            in_a_d  = code_zero;
            in_b_d  = code_zero;
            dac_a_d = code_zero;
            dac_b_d = code_zero;
            dirty_d = 2'h0;
            clr_d   = 1'b1;
        end
    end

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            in_a_q  <= '0;
            in_b_q  <= '0;
            dac_a_q <= '0;
            dac_b_q <= '0;
            dirty_q <= 2'h0;
            mask_q  <= `DDC_MASK_RST;
            pwr_q   <= '{mode_b: DDC_PWR_NORMAL, mode_a: DDC_PWR_NORMAL};
            ref_q   <= `DDC_REF_RST;
            clr_q   <= 1'b0;
        end else begin
            in_a_q  <= in_a_d;
            in_b_q  <= in_b_d;
            dac_a_q <= dac_a_d;
            dac_b_q <= dac_b_d;
            dirty_q <= dirty_d;
            mask_q  <= mask_d;
            pwr_q   <= pwr_d;
            ref_q   <= ref_d;
            clr_q   <= clr_d;
        end
    end

    // Abort, high-speed exit and shift clear are one-cycle pulses.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            abort_q <= 1'b0;
            hsx_q   <= 1'b0;
            shclr_q <= 1'b0;
        end else begin
            abort_q <= clr_evt & write_busy;
            hsx_q   <= clr_evt & hs_mode;
            shclr_q <= do_rst | clr_evt;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign dac_code_a  = dac_a_q;
    assign dac_code_b  = dac_b_q;
    assign pwr_mode    = pwr_q;
    assign ref_enable  = ref_q;
    assign load_bypass = mask_q;
    assign clear_mode  = clr_q;
    assign write_abort = abort_q;
    assign hs_exit     = hsx_q;
    assign shift_clear = shclr_q;
endmodule : ddc_ctrl

/* File: rtl/ddc_params.svh */
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// ---------------------------------------------------------------------------
// Command word fields
// ---------------------------------------------------------------------------
`define DDC_WORD_W       24
`define DDC_CMD_HI       21
`define DDC_CMD_LO       19
`define DDC_ADDR_HI      18
`define DDC_ADDR_LO      16
`define DDC_DATA_HI      15
`define DDC_PWR_HI       5
`define DDC_PWR_LO       4
`define DDC_SEL_B        1
`define DDC_SEL_A        0

// ---------------------------------------------------------------------------
// Command codes and addresses
// ---------------------------------------------------------------------------
`define DDC_CMD_WR_IN    3'h0
`define DDC_CMD_UPD      3'h1
`define DDC_CMD_WR_ALL   3'h2
`define DDC_CMD_WR_UPD   3'h3
`define DDC_CMD_PWR      3'h4
`define DDC_CMD_RST      3'h5
`define DDC_CMD_MASK     3'h6
`define DDC_CMD_REF      3'h7
`define DDC_ADDR_A       3'h0
`define DDC_ADDR_B       3'h1
`define DDC_ADDR_BOTH    3'h7

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define DDC_MASK_RST     2'h0
`define DDC_REF_RST      1'h0
`define DDC_PWR_RST      2'h0
`define DDC_CODE_RST     16'h0000
`define DDC_POR_CYC      3'h4

`endif

/* File: rtl/ddc_pkg.sv */
package ddc_pkg;

    typedef enum logic [1:0] {
        DDC_PWR_NORMAL = 2'b00,
        DDC_PWR_1K     = 2'b01,
        DDC_PWR_100K   = 2'b10,
        DDC_PWR_TRI    = 2'b11
    } ddc_pwr_t;

    typedef struct packed {
        logic       reserved;
        logic       byte_sel;
        logic [2:0] cmd;
        logic [2:0] addr;
        logic [15:0] data;
    } ddc_word_t;

    typedef struct packed {
        ddc_pwr_t   mode_b;
        ddc_pwr_t   mode_a;
    } ddc_pwr_pair_t;

endpackage : ddc_pkg

/* File: rtl/ddc_pin_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser; the level changes once stages two and three agree.
module ddc_pin_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Pin and result
    input  wire logic pin_in,
    output logic      level,
    output logic      fall
);
    logic [2:0] stg_q;
    logic       level_q;
    wire        agree = (stg_q[1] == stg_q[2]);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stg_q   <= 3'h7;
            level_q <= 1'b1;
        end else begin
            stg_q <= {stg_q[1:0], pin_in};
            if (agree) begin
                level_q <= stg_q[2];
            end
        end
    end

    assign level = level_q;
    assign fall  = level_q & agree & ~stg_q[2];
endmodule : ddc_pin_sync

/* File: sim/ddc_ctrl_props.sv */
`timescale 1ns/10ps
module ddc_ctrl_chk #(
    parameter int CODE_W = 16
) (
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    // Inputs
    input wire ddc_pkg::ddc_word_t     cmd_word,
    input wire logic                   cmd_valid,
    input wire logic                   write_busy,
    input wire logic                   hs_mode,
    input wire logic                   load_strobe_n,
    input wire logic                   async_zero_n,
    // Results
    input wire logic [CODE_W-1:0]      dac_code_a,
    input wire logic [CODE_W-1:0]      dac_code_b,
    input wire ddc_pkg::ddc_pwr_pair_t pwr_mode,
    input wire logic                   ref_enable,
    input wire logic [1:0]             load_bypass,
    input wire logic                   clear_mode,
    input wire logic                   write_abort,
    input wire logic                   hs_exit,
    input wire logic                   shift_clear
);
    import ddc_pkg::*;
    // Counts cycles with both pins high, so no pin event can collide with a command.
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    logic       acc;
    assign quiet_d = (!async_zero_n || !load_strobe_n) ? 4'h0 :
                     (quiet_q == 4'h8) ? quiet_q : quiet_q + 4'h1;
    assign acc = cmd_valid && (quiet_q == 4'h8);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) quiet_q <= 4'h0;
        else quiet_q <= quiet_d;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_RST_VAL: assert property ($rose(nrst) |-> dac_code_a == '0 && load_bypass == 2'h0)
        else $error("outputs not zero after reset");
    AST_MASK: assert property (acc && cmd_word.cmd == 3'h6
        |=> load_bypass == $past(cmd_word.data[1:0]))
        else $error("bypass mask not loaded");
    AST_REF: assert property (acc && cmd_word.cmd == 3'h7
        |=> ref_enable == $past(cmd_word.data[0]))
        else $error("reference enable wrong");
    AST_PWR: assert property (acc && cmd_word.cmd == 3'h4 && cmd_word.data[0]
        |=> pwr_mode.mode_a == $past(cmd_word.data[5:4]))
        else $error("channel a power mode wrong");
    AST_PWR_KEEP: assert property (acc && cmd_word.cmd == 3'h4 && !cmd_word.data[1]
        |=> $stable(pwr_mode.mode_b))
        else $error("unselected channel changed mode");
    AST_PD_CODE: assert property (acc && cmd_word.cmd == 3'h4
        |=> $stable(dac_code_a) && $stable(dac_code_b))
        else $error("power command changed a code");
    AST_WR_UPD: assert property (acc && cmd_word.cmd == 3'h3 && cmd_word.addr == 3'h0
        |=> dac_code_a == $past(cmd_word.data))
        else $error("write and update missed");
    AST_SW_RST: assert property (acc && cmd_word.cmd == 3'h5
        |=> dac_code_a == '0 && dac_code_b == '0 && shift_clear)
        else $error("soft reset left a code");
    AST_FULL_RST: assert property (acc && cmd_word.cmd == 3'h5 && cmd_word.data[0]
        |=> load_bypass == 2'h0 && pwr_mode == '0 && !ref_enable)
        else $error("full reset left a setting");
    AST_CLR_ZERO: assert property (clear_mode |-> dac_code_a == '0 && dac_code_b == '0)
        else $error("code not zero in clear mode");
    AST_ABORT: assert property (write_abort |-> $past(write_busy))
        else $error("abort without a write");
    AST_HS: assert property (hs_exit |-> $past(hs_mode))
        else $error("speed drop without high speed");
endmodule : ddc_ctrl_chk
bind ddc_ctrl ddc_ctrl_chk #(.CODE_W(CODE_W)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .write_busy(write_busy), .hs_mode(hs_mode), .load_strobe_n(load_strobe_n),
    .async_zero_n(async_zero_n), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
    .pwr_mode(pwr_mode), .ref_enable(ref_enable), .load_bypass(load_bypass),
    .clear_mode(clear_mode), .write_abort(write_abort), .hs_exit(hs_exit),
    .shift_clear(shift_clear));

/* File: sim/ddc_host_model.sv */
`timescale 1ns/10ps
module ddc_host_model (
    // Clock
    input wire logic           clk_sys,
    // Command side
    output ddc_pkg::ddc_word_t cmd_word,
    output logic               cmd_valid,
    output logic               write_busy,
    output logic               hs_mode,
    // Pins
    output logic               load_strobe_n,
    output logic               async_zero_n
);
    import ddc_pkg::*;
    initial begin
        cmd_word = '0;
        cmd_valid = 1'b0;
        write_busy = 1'b0;
        hs_mode = 1'b0;
        load_strobe_n = 1'b1;
        async_zero_n = 1'b1;
    end
    task automatic send(input logic [2:0] cmd, input logic [2:0] addr, input logic [15:0] data);
        @(negedge clk_sys);
        cmd_word = {1'b0, 1'b0, cmd, addr, data};
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_word = ~cmd_word;
    endtask : send
    // Strobe pulse of about one link period.
    task automatic strobe();
        @(negedge clk_sys);
        load_strobe_n = 1'b0;
        repeat (13) @(negedge clk_sys);
        load_strobe_n = 1'b1;
        repeat (10) @(negedge clk_sys);
    endtask : strobe
    task automatic clear_on();
        @(negedge clk_sys);
        write_busy = 1'b1;
        hs_mode = 1'b1;
        async_zero_n = 1'b0;
        repeat (13) @(negedge clk_sys);
        write_busy = 1'b0;
        hs_mode = 1'b0;
    endtask : clear_on
    task automatic clear_off();
        async_zero_n = 1'b1;
        repeat (10) @(negedge clk_sys);
    endtask : clear_off
endmodule : ddc_host_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import ddc_pkg::*;
    logic          clk_sys;
    logic          nrst;
    ddc_word_t     cmd_word;
    logic          cmd_valid;
    logic          write_busy;
    logic          hs_mode;
    logic          load_strobe_n;
    logic          async_zero_n;
    logic [15:0]   dac_code_a;
    logic [15:0]   dac_code_b;
    ddc_pwr_pair_t pwr_mode;
    logic          ref_enable;
    logic [1:0]    load_bypass;
    logic          clear_mode;
    logic          write_abort;
    logic          hs_exit;
    logic          shift_clear;
    logic          seen_abort = 1'b0;
    logic          seen_hs = 1'b0;
    int            mismatches = 0;
    int            checked = 0;
    ddc_host_model u_host (.clk_sys(clk_sys), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
        .write_busy(write_busy), .hs_mode(hs_mode), .load_strobe_n(load_strobe_n),
        .async_zero_n(async_zero_n));
    ddc_ctrl #(.CODE_W(16)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .cmd_word(cmd_word),
        .cmd_valid(cmd_valid), .write_busy(write_busy), .hs_mode(hs_mode),
        .load_strobe_n(load_strobe_n), .async_zero_n(async_zero_n), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b), .pwr_mode(pwr_mode), .ref_enable(ref_enable),
        .load_bypass(load_bypass), .clear_mode(clear_mode), .write_abort(write_abort),
        .hs_exit(hs_exit), .shift_clear(shift_clear));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        if (write_abort === 1'b1) seen_abort = 1'b1;
        if (hs_exit === 1'b1) seen_hs = 1'b1;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        nrst = 1'b0;
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk(dac_code_a, 16'h0000);
        chk({14'h0, load_bypass}, 16'h0000);
        chk({15'h0, ref_enable}, 16'h0000);
        $display("test reset done");
        u_host.send(3'h3, 3'h0, 16'h1234);
        chk(dac_code_a, 16'h1234);
        u_host.send(3'h0, 3'h1, 16'habcd);
        chk(dac_code_b, 16'h0000);
        u_host.strobe();
        chk(dac_code_b, 16'habcd);
        $display("test load done");
        u_host.send(3'h6, 3'h0, 16'h0002);
        chk({14'h0, load_bypass}, 16'h0002);
        u_host.send(3'h0, 3'h1, 16'h0f0f);
        chk(dac_code_b, 16'h0f0f);
        u_host.send(3'h0, 3'h0, 16'h1111);
        chk(dac_code_a, 16'h1234);
        $display("test bypass done");
        for (int m = 0; m < 4; m++) begin
            u_host.send(3'h4, 3'h0, {10'h0, m[1:0], 4'h1});
            chk({14'h0, pwr_mode.mode_a}, {14'h0, m[1:0]});
            chk({14'h0, pwr_mode.mode_b}, 16'h0000);
            chk(dac_code_a, 16'h1234);
        end
        u_host.send(3'h4, 3'h0, 16'h0022);
        chk({14'h0, pwr_mode.mode_b}, 16'h0002);
        chk({14'h0, pwr_mode.mode_a}, 16'h0003);
        $display("test power done");
        u_host.send(3'h7, 3'h0, 16'h0001);
        chk({15'h0, ref_enable}, 16'h0001);
        u_host.send(3'h5, 3'h0, 16'h0000);
        chk(dac_code_b, 16'h0000);
        chk({14'h0, load_bypass}, 16'h0002);
        u_host.send(3'h5, 3'h0, 16'h0001);
        chk({15'h0, ref_enable}, 16'h0000);
        chk({12'h0, pwr_mode}, 16'h0000);
        chk({14'h0, load_bypass}, 16'h0000);
        $display("test soft reset done");
        u_host.send(3'h0, 3'h7, 16'h2222);
        chk(dac_code_a, 16'h0000);
        u_host.send(3'h1, 3'h0, 16'h0000);
        chk(dac_code_a, 16'h2222);
        chk(dac_code_b, 16'h0000);
        u_host.send(3'h2, 3'h1, 16'h3333);
        chk(dac_code_a, 16'h2222);
        chk(dac_code_b, 16'h3333);
        $display("test update done");
        u_host.send(3'h3, 3'h0, 16'hff00);
        u_host.clear_on();
        chk(dac_code_a, 16'h0000);
        chk({15'h0, clear_mode}, 16'h0001);
        chk({15'h0, seen_abort}, 16'h0001);
        chk({15'h0, seen_hs}, 16'h0001);
        u_host.send(3'h0, 3'h0, 16'h1357);
        chk({15'h0, clear_mode}, 16'h0000);
        u_host.strobe();
        chk(dac_code_a, 16'h0000);
        u_host.clear_off();
        chk({15'h0, clear_mode}, 16'h0000);
        u_host.strobe();
        chk(dac_code_a, 16'h1357);
        $display("test clear done");
        nrst = 1'b0;
        u_host.clear_on();
        nrst = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk({15'h0, clear_mode}, 16'h0000);
        chk(dac_code_a, 16'h0000);
        u_host.clear_off();
        chk({15'h0, clear_mode}, 16'h0000);
        $display("test reset pins done");
        print_verdict();
    end
endmodule : testbench
